// ### common/dmau_pkg.sv
// data memory access unit: shared constants and state type
// assumes one 200 MHz clock and an asynchronous active-low reset
package dmau_pkg;
  // program memory vectors
  localparam logic [15:0] DMAU_RESET_VECTOR = 16'h0000; // first fetch after reset
  localparam logic [15:0] DMAU_VEC_BASE = 16'h0003; // first interrupt vector
  localparam int DMAU_VEC_SHIFT = 3; // vectors sit eight bytes apart
  // internal data space
  localparam logic [7:0] DMAU_LOWER_TOP = 8'h7f; // last lower-ram address
  localparam logic [7:0] DMAU_BIT_AREA = 8'h20; // first bit-addressable byte
  localparam logic [2:0] DMAU_SFR_BIT_LSB = 3'h0; // sfr bit-able low nibble 0 or 8
  // on-chip expanded ram
  localparam int DMAU_ONCHIP_EXPANDED_RAM_DEPTH = 3840; // bytes held
  localparam logic [15:0] DMAU_ONCHIP_EXPANDED_RAM_TOP = 16'h0eff; // last byte address
  localparam logic [7:0] DMAU_ONCHIP_EXPANDED_RAM_MISS = 8'hff; // read value beyond top
  localparam logic [7:0] DMAU_PAGE_ZERO = 8'h00; // high byte for 8-bit onchip_expanded_ram address
  // external bus
  localparam logic [7:0] DMAU_P0_FILL = 8'hff; // port 0 latch after external access
  localparam int DMAU_MODE_NOMUX_BIT = 1; // mode bit: no address phase
  localparam int DMAU_MODE_WIDE_BIT = 0; // mode bit: 16-bit data
  localparam logic [1:0] DMAU_MODE_MUX8 = 2'h0; // multiplexed, 8-bit data
  localparam logic [1:0] DMAU_MODE_MUX16 = 2'h1; // multiplexed, 16-bit data
  localparam logic [1:0] DMAU_MODE_NMX8 = 2'h2; // no address phase, 8-bit data
  localparam logic [1:0] DMAU_MODE_NMX16 = 2'h3; // no address phase, 16-bit data
  // access phases: idle, on-chip ram and external cycle
  typedef enum logic [2:0] {
    ST_IDLE, ST_ONCHIP_EXPANDED_RAM, ST_XRD, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD
  } dmau_state_t;
endpackage

// ### dv/dmau_top_test.sv
// self-checking bench for the data memory access unit
// assumes the package, the design and the memory model are compiled first
`timescale 1ns/1ps
module dmau_top_test;
  import dmau_pkg::*;
  // one expected move-external result
  typedef struct packed {
    logic rd;
    logic [15:0] data;
    logic [7:0] lat;
  } dmau_note_t;
  logic clk_i = 1'b0, arst_n_i = 1'b0;
  logic bank_select_hi_i = 1'b0, bank_select_lo_i = 1'b0, idx_use_pc_i = 1'b0;
  logic idx_jump_i = 1'b0, int_take_i = 1'b0, fetch_adv_i = 1'b0, req_i = 1'b0;
  logic req_write_i = 1'b0, req_wide_addr_i = 1'b0, offchip_data_select_i = 1'b0;
  logic strobe_setup_hold_sel_i = 1'b0, port0_latch_wr_i = 1'b0, xoff = 1'b0;
  logic [1:0] int_num_i = 2'h0, ext_mem_interface_mode_i = 2'h0, latch_pulse_width_sel_i = 2'h0;
  logic [2:0] reg_index_i = 3'h0, strobe_width_sel_i = 3'h0, bit_pos_o;
  logic [7:0] dir_addr_i = 8'h00, ind_addr_i = 8'h00, bit_addr_i = 8'h00, acc_i = 8'h00;
  logic [7:0] ind_reg_i = 8'h00, port2_latch_i = 8'h00, port0_latch_wdata_i = 8'h00, p0_i;
  logic [7:0] reg_ram_addr_o, bit_byte_addr_o, port0_latch_o, p0_o, p2_o, p2q = 8'h00;
  logic [15:0] pc_i = 16'h0000, data_pointer_i = 16'h0000, wdata_i = 16'h0000;
  logic dir_sfr_o, dir_sfr_bitable_o, ind_upper_o, busy_o, done_o, p0_oe_o, ale_o;
  logic read_strobe_n_o, write_strobe_n_o;
  logic [15:0] idx_addr_o, prog_addr_o, rdata_o, addr_seen, seed = 16'ha091, r, d, a, e;
  dmau_note_t notes [$]; // expected results in issue order
  dmau_note_t nt;
  int n_errors = 0, checks = 0, cyc = 0, t0 = 0, i;

  dmau_top i_dut (
    .clk_i, .arst_n_i, .bank_select_hi_i, .bank_select_lo_i, .reg_index_i, .dir_addr_i,
    .ind_addr_i, .bit_addr_i, .reg_ram_addr_o, .dir_sfr_o, .dir_sfr_bitable_o, .ind_upper_o,
    .bit_byte_addr_o, .bit_pos_o, .pc_i, .data_pointer_i, .acc_i, .idx_use_pc_i, .idx_jump_i,
    .int_take_i, .int_num_i, .fetch_adv_i, .idx_addr_o, .prog_addr_o, .req_i, .req_write_i,
    .req_wide_addr_i, .ind_reg_i, .wdata_i, .offchip_data_select_i, .ext_mem_interface_mode_i,
    .latch_pulse_width_sel_i, .strobe_width_sel_i, .strobe_setup_hold_sel_i, .busy_o, .done_o,
    .rdata_o, .port2_latch_i, .port0_latch_wr_i, .port0_latch_wdata_i, .port0_latch_o, .p0_i,
    .p0_o, .p0_oe_o, .p2_o, .ale_o, .read_strobe_n_o, .write_strobe_n_o
  );
  dmau_xmem_model i_mem (
    .fifo_mode_i(ext_mem_interface_mode_i[1]), .bus_i(p0_o), .bus_oe_i(p0_oe_o), .page_i(p2_o),
    .ale_i(ale_o), .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o), .data_o(p0_i),
    .addr_o(addr_seen)
  );

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // pseudo-random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one move-external access with random timing knobs; expectation noted first
  task automatic xfer(input logic wr, input logic off, input logic [1:0] md, input logic [15:0] ea);
    int lat;
    seed = lfsr(seed);
    lat = 1 + (md[1] ? 0 : 2 * (seed[5:4] + 1)) + (md[0] + 1) * (2 * seed[0] + seed[3:1] + 3);
    if (!off) lat = 3;
    notes.push_back('{~wr, ea, lat[7:0]});
    @(posedge clk_i);
    port0_latch_wr_i <= 1'b1;
    port0_latch_wdata_i <= {1'b0, seed[14:8]};
    @(posedge clk_i);
    xoff = off;
    port0_latch_wr_i <= 1'b0;
    {req_i, req_write_i, offchip_data_select_i, ext_mem_interface_mode_i} <= {1'b1, wr, off, md};
    {latch_pulse_width_sel_i, strobe_width_sel_i, strobe_setup_hold_sel_i} <= seed[5:0];
    req_wide_addr_i <= seed[6] | ~off;
    {port2_latch_i, ind_reg_i, data_pointer_i, wdata_i} <= {a, a, d};
    @(posedge clk_i);
    req_i <= 1'b0;
    for (lat = 0; lat < 300 && done_o !== 1'b1; lat++) @(posedge clk_i);
    check(port0_latch_o, off ? 8'hff : {1'b0, seed[14:8]});
    if (off && !md[1]) check(addr_seen, a);
  endtask

  // pin watch outside external cycles, done pulses matched to the oldest note, hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish();
    end
    if (req_i === 1'b1 && busy_o === 1'b0) t0 = cyc;
    if (arst_n_i && (!xoff || (busy_o !== 1'b1 && done_o !== 1'b1))) begin
      check({ale_o, read_strobe_n_o, write_strobe_n_o, p0_oe_o}, 4'h6);
      check(p2_o, p2q);
    end
    // on-chip cycle keeps port 2 where it was
    if (busy_o !== 1'b1 && !(req_i === 1'b1 && offchip_data_select_i === 1'b0)) p2q = port2_latch_i;
    if (done_o === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check(16'(cyc - t0), nt.lat);
      if (nt.rd) check(rdata_o, nt.data);
    end
  end

  // main sequence: reset, decode, program addressing, move-external
  initial begin
    @(negedge clk_i);
    check(prog_addr_o, DMAU_RESET_VECTOR);
    check(port0_latch_o, DMAU_P0_FILL); // latch reset value
    @(posedge clk_i);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      r = lfsr(seed);
      @(posedge clk_i);
      {bank_select_hi_i, bank_select_lo_i, reg_index_i, dir_addr_i} <= {seed[4:0], seed[15:8]};
      {ind_addr_i, bit_addr_i} <= r;
      @(posedge clk_i);
      @(negedge clk_i);
      check(reg_ram_addr_o, {3'h0, seed[4:0]});
      e = {seed[15], seed[15] && seed[10:8] == 3'h0, r[15]};
      check({dir_sfr_o, dir_sfr_bitable_o, ind_upper_o}, e);
      e = {r[7] ? {r[7:3], 3'h0} : 8'h20 + r[6:3], r[2:0]};
      check({bit_byte_addr_o, bit_pos_o}, e);
    end
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r = lfsr(seed);
      @(posedge clk_i);
      {int_take_i, idx_jump_i, int_num_i, idx_use_pc_i} <= {2'h3, i[1:0], seed[0]};
      {pc_i, data_pointer_i, acc_i} <= {seed, r, r[15:8]};
      @(posedge clk_i);
      int_take_i <= 1'b0;
      @(negedge clk_i);
      check(prog_addr_o, 16'h0003 + 16'(i * 8));
      e = (seed[0] ? seed : r) + r[15:8];
      @(posedge clk_i);
      {idx_jump_i, fetch_adv_i} <= 2'h1;
      @(negedge clk_i);
      check(idx_addr_o, e);
      check(prog_addr_o, e);
      @(posedge clk_i);
      fetch_adv_i <= 1'b0;
      @(negedge clk_i);
      check(prog_addr_o, e + 16'h0001); // next sequential fetch
    end
    for (i = 0; i < 11; i++) begin
      seed = lfsr(seed);
      a = lfsr(seed);
      d = seed;
      if (i >= 8) a = (i == 8) ? 16'h0eff : a % 16'h0f00;
      xfer(1'b1, i < 8, i[1:0] & {2{i < 8}}, 16'h0000);
      xfer(1'b0, i < 8, i[1:0] & {2{i < 8}}, (i < 8 && i[0]) ? d : {8'h00, d[7:0]});
    end
    a = 16'h0f00;
    xfer(1'b0, 1'b0, 2'h0, 16'h00ff); // past the top of on-chip ram
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule // dmau_top_test

// ### dv/dmau_xmem_model.sv
// external memory model: multiplexed sram behind an address latch, or fifo
// assumes the bench says which style the bus is in
`timescale 1ns/1ps
module dmau_xmem_model (
  input wire logic fifo_mode_i,
  input wire logic [7:0] bus_i,
  input wire logic bus_oe_i,
  input wire logic [7:0] page_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [7:0] data_o,
  output logic [15:0] addr_o
);
  logic [7:0] mem [logic [16:0]]; // sram bytes keyed by address and slot
  logic [7:0] fifo [$]; // fifo-style contents
  logic [7:0] rd_val = 8'h00; // byte under the read strobe
  logic [7:0] last_val = 8'h00; // last byte seen on the bus
  logic slot = 1'b0; // byte slot within a 16-bit transfer
  // address taken as the latch strobe falls
  always @(negedge ale_i) begin
    addr_o = {page_i, bus_i};
    slot = 1'b0;
  end
  // read byte picked as the strobe falls; fifo style needs no address
  always @(negedge rd_n_i) begin
    if (fifo_mode_i) rd_val = (fifo.size() > 0) ? fifo.pop_front() : 8'h00;
    else if (mem.exists({addr_o, slot})) rd_val = mem[{addr_o, slot}];
    else rd_val = 8'h00;
  end
  always @(posedge rd_n_i) begin
    last_val = rd_val;
    slot = ~slot;
  end
  // write byte still on the bus as the active-low strobe rises
  always @(posedge wr_n_i) begin
    if (bus_oe_i === 1'b1 && fifo_mode_i) fifo.push_back(bus_i);
    else if (bus_oe_i === 1'b1) mem[{addr_o, slot}] = bus_i;
    last_val = bus_i;
    slot = ~slot;
  end
  // memory drives only under the read strobe; a released bus shows a stale inverse
  assign data_o = bus_oe_i ? bus_i : ((rd_n_i === 1'b0) ? rd_val : ~last_val);
endmodule // dmau_xmem_model

// ### verilog/dmau_onchip_expanded_ram.sv
// on-chip expanded ram: byte array with one synchronous port
// assumes the caller keeps addresses inside the array for writes
`timescale 1ns/1ps
module dmau_onchip_expanded_ram
  import dmau_pkg::*;
(
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DMAU_ONCHIP_EXPANDED_RAM_DEPTH]; // byte storage
  logic hit; // address inside the array

  assign hit = (addr_i <= DMAU_ONCHIP_EXPANDED_RAM_TOP);

  // one access per enabled cycle; out-of-range writes dropped
  always_ff @(posedge clk_i) begin
    if (en_i && we_i && hit) begin
      mem[addr_i[11:0]] <= wdata_i;
    end
  end

  // registered read; beyond the top reads as all ones
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      rdata_o <= hit ? mem[addr_i[11:0]] : DMAU_ONCHIP_EXPANDED_RAM_MISS;
    end
  end
endmodule // dmau_onchip_expanded_ram

// ### verilog/dmau_top.sv
// data memory access unit: internal address decode, program vectors,
// and the move-external path to on-chip ram or the external data bus
// assumes all inputs but arst_n_i synchronous to clk_i; port 0 is resolved outside
//
// What this block does
// RULE1 - opcode 3-bit field picks bank register
// RULE2 - indexed read and jump use base plus accumulator
// RULE3 - first fetch comes from address 0000H
// RULE4 - interrupt vectors fixed, eight bytes apart
// RULE5 - program memory read-only, on-chip, no external fetch
// RULE6 - above 7FH: direct is sfr, indirect upper ram
// RULE7 - low 32 bytes form four banks of eight
// RULE8 - sixteen bytes above banks hold 128 bits
// RULE9 - lower ram any mode, upper ram indirect only
// RULE10 - sfr direct only; x0H/x8H also bit-addressable
// RULE11 - select bit routes accesses on-chip or off-chip
// RULE12 - on-chip ram holds 3840 bytes, move-external only
// RULE13 - on-chip access leaves every bus pin unchanged
// RULE14 - 8-bit address keeps port 2 latch on pins
// RULE15 - 16-bit address drives high byte on port 2
// RULE16 - multiplexed address valid at latch strobe fall
// RULE17 - write data surrounds the write strobe
// RULE18 - read data sampled just before strobe release
// RULE19 - external access fills port 0 latch with ones
// RULE20 - no-address mode skips the address phase
// RULE21 - active-low read and write strobes qualify transfers
// RULE22 - two-bit mode field picks bus style
// RULE23 - latch strobe phases last one to four cycles
// RULE24 - strobe width is field plus one cycles
// RULE25 - setup and hold are one or two cycles
// RULE26 - strobes inactive outside external cycles
// RULE27 - register address is bank times eight plus index
`timescale 1ns/1ps
module dmau_top
  import dmau_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register and internal address decode
  input wire logic bank_select_hi_i,
  input wire logic bank_select_lo_i,
  input wire logic [2:0] reg_index_i,
  input wire logic [7:0] dir_addr_i,
  input wire logic [7:0] ind_addr_i,
  input wire logic [7:0] bit_addr_i,
  output logic [7:0] reg_ram_addr_o,
  output logic dir_sfr_o,
  output logic dir_sfr_bitable_o,
  output logic ind_upper_o,
  output logic [7:0] bit_byte_addr_o,
  output logic [2:0] bit_pos_o,
  // program memory addressing
  input wire logic [15:0] pc_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] acc_i,
  input wire logic idx_use_pc_i,
  input wire logic idx_jump_i,
  input wire logic int_take_i,
  input wire logic [1:0] int_num_i,
  input wire logic fetch_adv_i,
  output logic [15:0] idx_addr_o,
  output logic [15:0] prog_addr_o,
  // move-external request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_wide_addr_i,
  input wire logic [7:0] ind_reg_i,
  input wire logic [15:0] wdata_i,
  input wire logic offchip_data_select_i,
  input wire logic [1:0] ext_mem_interface_mode_i,
  input wire logic [1:0] latch_pulse_width_sel_i,
  input wire logic [2:0] strobe_width_sel_i,
  input wire logic strobe_setup_hold_sel_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // port latches
  input wire logic [7:0] port2_latch_i,
  input wire logic port0_latch_wr_i,
  input wire logic [7:0] port0_latch_wdata_i,
  output logic [7:0] port0_latch_o,
  // external pins
  input wire logic [7:0] p0_i,
  output logic [7:0] p0_o,
  output logic p0_oe_o,
  output logic [7:0] p2_o,
  output logic ale_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o
);
  dmau_state_t state_reg; // bus cycle phase
  logic [2:0] cnt_reg; // cycles left in phase, minus one
  logic [15:0] addr_reg; // captured access address
  logic [15:0] wdata_reg; // captured write data
  logic write_reg; // access is a write
  logic wide_addr_reg; // access uses 16-bit address
  logic [1:0] mode_reg; // captured interface mode
  logic [1:0] alw_reg; // captured latch strobe width
  logic [2:0] rws_reg; // captured strobe width
  logic sh_reg; // captured setup/hold select
  logic byte_hi_reg; // second byte of 16-bit data
  logic onchip_expanded_ram_en_reg; // on-chip ram enable
  logic onchip_expanded_ram_we_reg; // on-chip ram write
  logic [7:0] onchip_expanded_ram_rdata; // on-chip ram read data
  logic start_ext; // external access taken this cycle
  logic [15:0] req_addr; // address of incoming request
  logic [15:0] idx_sum; // base plus accumulator

  // upper half of the 8-bit internal space
  function automatic logic is_upper(input logic [7:0] a);
    return a > DMAU_LOWER_TOP;
  endfunction

  assign req_addr = req_wide_addr_i ? data_pointer_i : {DMAU_PAGE_ZERO, ind_reg_i};
  assign start_ext = (state_reg == ST_IDLE) && req_i && offchip_data_select_i;
  assign idx_sum = (idx_use_pc_i ? pc_i : data_pointer_i) + {8'h00, acc_i}; // [RULE2]

  // internal data space decode, registered
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_ram_addr_o <= 8'h00;
      dir_sfr_o <= 1'b0;
      dir_sfr_bitable_o <= 1'b0;
      ind_upper_o <= 1'b0;
      bit_byte_addr_o <= 8'h00;
      bit_pos_o <= 3'h0;
    end else begin
      // bank times eight plus opcode index, no address byte
      reg_ram_addr_o <= {3'h0, bank_select_hi_i, bank_select_lo_i, reg_index_i}; // [RULE1] [RULE7] [RULE27]
      // direct above 7FH is sfr; lower half is ram either way
      dir_sfr_o <= is_upper(dir_addr_i); // [RULE6] [RULE9] [RULE10]
      dir_sfr_bitable_o <= is_upper(dir_addr_i) && (dir_addr_i[2:0] == DMAU_SFR_BIT_LSB); // [RULE10]
      // indirect above 7FH reaches the separate upper ram
      ind_upper_o <= is_upper(ind_addr_i); // [RULE6] [RULE9]
      bit_pos_o <= bit_addr_i[2:0];
      if (is_upper(bit_addr_i)) begin
        // sfr bit: byte is the bit address with low three bits cleared
        bit_byte_addr_o <= {bit_addr_i[7:3], 3'h0}; // [RULE10]
      end else begin
        // ram bit: sixteen bytes above the banks
        bit_byte_addr_o <= DMAU_BIT_AREA + {4'h0, bit_addr_i[6:3]}; // [RULE8]
      end
    end
  end

  // program memory addressing; read-only, no external fetch path
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prog_addr_o <= DMAU_RESET_VECTOR; // [RULE3]
      idx_addr_o <= 16'h0000;
    end else begin
      idx_addr_o <= idx_sum; // [RULE2] [RULE5]
      if (int_take_i) begin
        // fixed vectors eight bytes apart
        prog_addr_o <= DMAU_VEC_BASE + ({14'h0000, int_num_i} << DMAU_VEC_SHIFT); // [RULE4]
      end else if (idx_jump_i) begin
        prog_addr_o <= idx_sum; // [RULE2]
      end else if (fetch_adv_i) begin
        prog_addr_o <= prog_addr_o + 16'h0001;
      end
    end
  end

  // port 0 latch; external access fill beats a software write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port0_latch_o <= DMAU_P0_FILL;
    end else if (start_ext) begin
      port0_latch_o <= DMAU_P0_FILL; // [RULE19]
    end else if (port0_latch_wr_i) begin
      port0_latch_o <= port0_latch_wdata_i;
    end
  end

  // move-external sequencer and bus pins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      write_reg <= 1'b0;
      wide_addr_reg <= 1'b0;
      mode_reg <= DMAU_MODE_MUX8;
      alw_reg <= 2'h0;
      rws_reg <= 3'h0;
      sh_reg <= 1'b0;
      byte_hi_reg <= 1'b0;
      onchip_expanded_ram_en_reg <= 1'b0;
      onchip_expanded_ram_we_reg <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      p0_o <= 8'h00;
      p0_oe_o <= 1'b0;
      p2_o <= 8'h00;
      ale_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      onchip_expanded_ram_en_reg <= 1'b0;
      onchip_expanded_ram_we_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          // strobes rest inactive; port 2 follows its latch
          ale_o <= 1'b0; // [RULE26]
          read_strobe_n_o <= 1'b1; // [RULE26]
          write_strobe_n_o <= 1'b1; // [RULE26]
          p2_o <= port2_latch_i;
          if (req_i) begin
            busy_o <= 1'b1;
            addr_reg <= req_addr;
            wdata_reg <= wdata_i;
            write_reg <= req_write_i;
            wide_addr_reg <= req_wide_addr_i;
            mode_reg <= ext_mem_interface_mode_i; // [RULE22]
            alw_reg <= latch_pulse_width_sel_i;
            rws_reg <= strobe_width_sel_i;
            sh_reg <= strobe_setup_hold_sel_i;
            byte_hi_reg <= 1'b0;
            if (!offchip_data_select_i) begin
              // on-chip ram: no pin moves at all
              onchip_expanded_ram_en_reg <= 1'b1; // [RULE11] [RULE12] [RULE13]
              onchip_expanded_ram_we_reg <= req_write_i;
              p2_o <= p2_o; // [RULE13]
              state_reg <= ST_ONCHIP_EXPANDED_RAM;
            end else begin
              // high address byte or latch contents on port 2
              p2_o <= req_wide_addr_i ? req_addr[15:8] : port2_latch_i; // [RULE14] [RULE15]
              if (!ext_mem_interface_mode_i[DMAU_MODE_NOMUX_BIT]) begin
                // multiplexed: low address on port 0 with latch strobe
                p0_o <= req_addr[7:0]; // [RULE16]
                p0_oe_o <= 1'b1;
                ale_o <= 1'b1; // [RULE16]
                cnt_reg <= {1'b0, latch_pulse_width_sel_i}; // [RULE23]
                state_reg <= ST_ALE_HI;
              end else begin
                // no address phase: straight to data setup
                p0_o <= wdata_i[7:0]; // [RULE20]
                p0_oe_o <= req_write_i;
                cnt_reg <= {2'h0, strobe_setup_hold_sel_i}; // [RULE25]
                state_reg <= ST_SETUP;
              end
            end
          end
        end
        ST_ONCHIP_EXPANDED_RAM: begin
          state_reg <= ST_XRD;
        end
        ST_XRD: begin
          rdata_o <= {8'h00, onchip_expanded_ram_rdata}; // [RULE12]
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_ALE_HI: begin
          if (cnt_reg == 3'h0) begin
            // address still driven across the falling edge
            ale_o <= 1'b0; // [RULE16]
            cnt_reg <= {1'b0, alw_reg}; // [RULE23]
            state_reg <= ST_ALE_LO;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_ALE_LO: begin
          if (cnt_reg == 3'h0) begin
            // turn port 0 over to data
            p0_o <= wdata_reg[7:0]; // [RULE16]
            p0_oe_o <= write_reg;
            cnt_reg <= {2'h0, sh_reg}; // [RULE25]
            state_reg <= ST_SETUP;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == 3'h0) begin
            // data settled; assert the active-low strobe
            read_strobe_n_o <= write_reg; // [RULE21]
            write_strobe_n_o <= !write_reg; // [RULE17] [RULE21]
            cnt_reg <= rws_reg; // [RULE24]
            state_reg <= ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_STROBE: begin
          if (cnt_reg == 3'h0) begin
            // sample in the last strobe cycle, then release
            if (!write_reg) begin
              if (byte_hi_reg) begin
                rdata_o[15:8] <= p0_i; // [RULE18]
              end else begin
                rdata_o <= {8'h00, p0_i}; // [RULE18]
              end
            end
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            cnt_reg <= {2'h0, sh_reg}; // [RULE25]
            state_reg <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_HOLD: begin
          if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
          end else if (mode_reg[DMAU_MODE_WIDE_BIT] && !byte_hi_reg) begin
            // 16-bit data: second transfer carries the high byte
            byte_hi_reg <= 1'b1; // [RULE22]
            p0_o <= wdata_reg[15:8];
            cnt_reg <= {2'h0, sh_reg};
            state_reg <= ST_SETUP;
          end else begin
            // write data held until here, past the strobe
            p0_oe_o <= 1'b0; // [RULE17]
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // on-chip expanded ram
  dmau_onchip_expanded_ram u_onchip_expanded_ram (
    .clk_i(clk_i),
    .en_i(onchip_expanded_ram_en_reg),
    .we_i(onchip_expanded_ram_we_reg),
    .addr_i(addr_reg),
    .wdata_i(wdata_reg[7:0]),
    .rdata_o(onchip_expanded_ram_rdata)
  );

  // helper run-length counters for the checks below
  logic [3:0] ale_run_reg; // cycles latch strobe has been high
  logic [3:0] stb_run_reg; // cycles a strobe has been low
  logic [3:0] setup_run_reg; // cycles spent in the setup phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ale_run_reg <= 4'h0;
      stb_run_reg <= 4'h0;
      setup_run_reg <= 4'h0;
    end else begin
      setup_run_reg <= (state_reg == ST_SETUP) ? setup_run_reg + 4'h1 : 4'h0;
      ale_run_reg <= ale_o ? ale_run_reg + 4'h1 : 4'h0;
      stb_run_reg <= (!read_strobe_n_o || !write_strobe_n_o) ? stb_run_reg + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  strobe_idle_a : assert property ( // [RULE26]
    state_reg == ST_IDLE |-> read_strobe_n_o && write_strobe_n_o && !ale_o)
    else $error("strobe active outside an external cycle");
  onchip_expanded_ram_quiet_a : assert property ( // [RULE13]
    state_reg inside {ST_ONCHIP_EXPANDED_RAM, ST_XRD} |-> $stable(p0_oe_o) && $stable(p2_o) && $stable(ale_o)
      && $stable(read_strobe_n_o) && $stable(write_strobe_n_o))
    else $error("bus pin moved during on-chip ram access");
  p2_high_a : assert property ( // [RULE15]
    state_reg == ST_STROBE && wide_addr_reg |-> p2_o == addr_reg[15:8])
    else $error("port 2 lost high address byte");
  p2_page_a : assert property ( // [RULE14]
    $past(state_reg) != ST_IDLE && state_reg != ST_IDLE && !onchip_expanded_ram_en_reg |-> $stable(p2_o))
    else $error("port 2 changed inside the cycle");
  ale_width_a : assert property ( // [RULE23]
    $fell(ale_o) |-> ale_run_reg == {2'h0, alw_reg} + 4'h1)
    else $error("latch strobe high phase wrong length");
  stb_width_a : assert property ( // [RULE24]
    $rose(read_strobe_n_o) || $rose(write_strobe_n_o) |-> stb_run_reg == {1'b0, rws_reg} + 4'h1)
    else $error("strobe width wrong");
  wr_data_a : assert property ( // [RULE17]
    $fell(write_strobe_n_o) |-> p0_oe_o && $past(p0_oe_o) ##1 p0_oe_o [*1])
    else $error("write data not around strobe");
  fill_p0_a : assert property ( // [RULE19]
    start_ext |=> port0_latch_o == DMAU_P0_FILL)
    else $error("port 0 latch not filled");
  nomux_ale_a : assert property ( // [RULE20]
    busy_o && mode_reg[DMAU_MODE_NOMUX_BIT] |-> !ale_o)
    else $error("latch strobe in no-address mode");
  setup_a : assert property ( // [RULE25]
    $fell(read_strobe_n_o) || $fell(write_strobe_n_o) |-> setup_run_reg == {3'h0, sh_reg} + 4'h1)
    else $error("strobe setup time wrong");
  bank_addr_a : assert property ( // [RULE27]
    ##1 reg_ram_addr_o == {3'h0, $past(bank_select_hi_i), $past(bank_select_lo_i),
      $past(reg_index_i)})
    else $error("bank register address wrong");

  mux_read_c : cover property (start_ext && !req_write_i && ext_mem_interface_mode_i == DMAU_MODE_MUX8);
  nmx16_wr_c : cover property (done_o && write_reg && mode_reg == DMAU_MODE_NMX16);
  onchip_expanded_ram_c : cover property (state_reg == ST_XRD);
  mux16_c : cover property (done_o && mode_reg == DMAU_MODE_MUX16);
endmodule // dmau_top
